// ---- inc/swm_defines.svh ----
`ifndef SWM_DEFINES_SVH
`define SWM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------------
`define SWM_FRAME_BITS      24
`define SWM_CNT_W           5
`define SWM_CNT_FULL        5'h18
`define SWM_CNT_MAX         5'h1f
`define SWM_STAT_INT_BIT    23
`define SWM_STAT_THERM_BIT  22

// ----------------------------------------------------------------------------
// Switch input counts
// ----------------------------------------------------------------------------
`define SWM_SP_COUNT        8
`define SWM_SG_COUNT        14
`define SWM_SW_COUNT        22

// ----------------------------------------------------------------------------
// Synchroniser lanes and their reset levels
// ----------------------------------------------------------------------------
`define SWM_PIN_COUNT       6
`define SWM_PIN_CS          0
`define SWM_PIN_SCLK        1
`define SWM_PIN_SI          2
`define SWM_PIN_INT         3
`define SWM_PIN_WAKE        4
`define SWM_PIN_VDD         5
`define SWM_PIN_RST_VAL     6'h19
`define SWM_SYNC_W          28
`define SWM_SYNC_RST_VAL    28'h0000019

// ----------------------------------------------------------------------------
// Change detection start-up
// ----------------------------------------------------------------------------
`define SWM_PRIME_W         3
`define SWM_PRIME_CYCLES    3'h5

`endif

// ---- inc/swm_pkg.sv ----
package swm_pkg;

    // ------------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        SWM_NORMAL = 1'b0,
        SWM_SLEEP  = 1'b1
    } swm_mode_type;

endpackage : swm_pkg

// ---- inc/swm_sw_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------------
// Switch state carrier between the sampler and the serial logic
// ----------------------------------------------------------------------------
interface swm_sw_if #(
    parameter int N = 22
);
    logic [N-1:0] closed;
    logic         changed;

    modport src (output closed, output changed);
    modport dst (input closed, input changed);
endinterface : swm_sw_if

`default_nettype wire

// ---- design/swm_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "swm_defines.svh"

// ----------------------------------------------------------------------------
// Three-stage synchroniser with agreement filter
// ----------------------------------------------------------------------------
module swm_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    genvar g;

    // Stage one is read only by stage two; the output follows once stages
    // two and three agree, which suppresses a single-cycle glitch.
    generate
        for (g = 0; g < W; g++) begin : g_lane
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1      <= RST_VAL[g];
                    s2      <= RST_VAL[g];
                    s3      <= RST_VAL[g];
                    dout[g] <= RST_VAL[g];
                end else begin
                    s1 <= din[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        dout[g] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule : swm_sync

`default_nettype wire

// ---- design/swm_sampler.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "swm_defines.svh"

// ----------------------------------------------------------------------------
// Switch sense conversion and change detection
// ----------------------------------------------------------------------------
module swm_sampler
    import swm_pkg::*;
#(
    parameter int SP = `SWM_SP_COUNT,
    parameter int SG = `SWM_SG_COUNT
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [SP-1:0] sp_above,
    input  wire logic [SG-1:0] sg_above,
    input  wire logic [SP-1:0] sp_battery_sel,
    input  wire logic [SP+SG-1:0] int_enable,
    swm_sw_if.src             sw
);

    logic [SP-1:0]    sp_closed;
    logic [SP+SG-1:0] prev;
    logic [`SWM_PRIME_W-1:0] prime_cnt;
    wire              primed     = (prime_cnt == `SWM_PRIME_CYCLES);
    wire  [SP+SG-1:0] now_closed = {~sg_above, sp_closed};
    wire  [SP+SG-1:0] diff       = (now_closed ^ prev) & int_enable;

    genvar g;

    // Battery-switched inputs close above the threshold, ground-switched ones
    // below it; either way a closed switch reads as one.
    generate
        for (g = 0; g < SP; g++) begin : g_sp
            assign sp_closed[g] = sp_battery_sel[g] ? sp_above[g] : ~sp_above[g];
        end
    endgenerate

    // Changes count only once the synchronisers have filled and the history
    // holds real pin levels; otherwise the arrival of the pin levels after
    // reset would look like a switch change and raise a false interrupt.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev       <= '0;
            prime_cnt  <= '0;
            sw.closed  <= '0;
            sw.changed <= 1'b0;
        end else begin
            prev       <= now_closed;
            if (!primed) begin
                prime_cnt <= prime_cnt + 1'b1;
            end
            sw.closed  <= now_closed;
            sw.changed <= primed && (diff != '0);
        end
    end

endmodule : swm_sampler

`default_nettype wire

// ---- design/swm_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "swm_defines.svh"

module swm_top
    import swm_pkg::*;
#(
    parameter int SP = `SWM_SP_COUNT,
    parameter int SG = `SWM_SG_COUNT
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            cs_n_in,
    input  wire logic            sclk_in,
    input  wire logic            si_in,
    output logic                 so_out,
    output logic                 so_oe,
    input  wire logic            int_n_in,
    output logic                 int_n_out,
    output logic                 int_n_oe,
    input  wire logic            wake_n_in,
    output logic                 wake_n_out,
    output logic                 wake_n_oe,
    input  wire logic            vdd_present,
    input  wire logic [SP-1:0]   prog_polarity_inputs,
    input  wire logic [SG-1:0]   ground_only_inputs,
    input  wire logic [SP-1:0]   sp_battery_sel,
    input  wire logic [SP+SG-1:0] int_enable,
    input  wire logic            thermal_flag,
    input  wire logic            sleep_req,
    output logic [`SWM_FRAME_BITS-1:0] cmd_word,
    output logic                 cmd_valid,
    output logic                 mode_normal
);

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------

    logic [`SWM_SYNC_W-1:0] sync_q;
    wire  [`SWM_SYNC_W-1:0] sync_d = {ground_only_inputs, prog_polarity_inputs,
                                      vdd_present, wake_n_in, int_n_in,
                                      si_in, sclk_in, cs_n_in};

    // Every pin, including the serial clock, is sampled by the local clock;
    // the serial clock must stay well below a quarter of the local rate.
    swm_sync #(
        .W       (`SWM_SYNC_W),
        .RST_VAL (`SWM_SYNC_RST_VAL)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (sync_d),
        .dout  (sync_q)
    );

    wire cs_q   = sync_q[`SWM_PIN_CS];
    wire sclk_q = sync_q[`SWM_PIN_SCLK];
    wire si_q   = sync_q[`SWM_PIN_SI];
    wire int_q  = sync_q[`SWM_PIN_INT];
    wire wake_q = sync_q[`SWM_PIN_WAKE];
    wire vdd_q  = sync_q[`SWM_PIN_VDD];

    // ------------------------------------------------------------------------
    // Switch sampling
    // ------------------------------------------------------------------------

    swm_sw_if #(.N(SP + SG)) sw_bus ();

    swm_sampler #(
        .SP (SP),
        .SG (SG)
    ) u_sampler (
        .clk            (clk),
        .rst_n          (rst_n),
        .sp_above       (sync_q[`SWM_PIN_COUNT +: SP]),
        .sg_above       (sync_q[`SWM_PIN_COUNT + SP +: SG]),
        .sp_battery_sel (sp_battery_sel),
        .int_enable     (int_enable),
        .sw             (sw_bus.src)
    );

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------

    logic cs_prev;
    logic sclk_prev;
    logic int_prev;
    logic wake_prev;

    // Previous levels of the filtered pins, reset to their idle levels.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev   <= 1'b1;
            sclk_prev <= 1'b0;
            int_prev  <= 1'b1;
            wake_prev <= 1'b1;
        end else begin
            cs_prev   <= cs_q;
            sclk_prev <= sclk_q;
            int_prev  <= int_q;
            wake_prev <= wake_q;
        end
    end

    // Without the logic supply the serial port is dead, so its select falls vanish.
    wire cs_fall   = cs_prev & ~cs_q & vdd_q;
    wire cs_rise   = ~cs_prev & cs_q;
    wire int_fall  = int_prev & ~int_q;
    wire wake_fall = wake_prev & ~wake_q;

    // ------------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------------

    logic                         sel;
    logic                         frame_ok;
    logic [`SWM_CNT_W-1:0]        bit_cnt;
    logic [`SWM_FRAME_BITS-1:0]   rx_shift;
    logic [`SWM_FRAME_BITS-1:0]   tx_shift;
    logic                         int_pending;
    logic                         chg_in_frame;
    swm_mode_type                 mode;
    swm_mode_type                 next_mode;

    // Clock edges count only inside a frame; the master keeps the clock low
    // around select edges, so a select edge never doubles as a clock edge.
    wire sclk_rise = sel & ~sclk_prev & sclk_q & ~cs_q;
    wire sclk_fall = sel & sclk_prev & ~sclk_q & ~cs_q;

    // Status word: interrupt flag, thermal flag, then all switch states.
    wire [`SWM_FRAME_BITS-1:0] status_word = {int_pending, thermal_flag, sw_bus.closed};

    wire word_complete = (bit_cnt == `SWM_CNT_FULL);
    wire commit        = cs_rise & sel & frame_ok & word_complete;
    wire [`SWM_CNT_W-1:0] next_cnt = (bit_cnt == `SWM_CNT_MAX) ? bit_cnt : bit_cnt + 1'b1;

    // Frame open flag; a select fall opens, a select rise closes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel      <= 1'b0;
            frame_ok <= 1'b0;
        end else if (cs_fall) begin
            sel      <= 1'b1;
            frame_ok <= (mode == SWM_NORMAL);
        end else if (cs_rise || !vdd_q) begin
            sel      <= 1'b0;
            frame_ok <= 1'b0;
        end
    end

    // Command input: each falling serial clock shifts SI in at the bottom,
    // so the first bit sent ends up as the most significant one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift <= '0;
            bit_cnt  <= '0;
        end else if (cs_fall) begin
            bit_cnt <= '0;
        end else if (sclk_fall) begin
            rx_shift <= {rx_shift[`SWM_FRAME_BITS-2:0], si_q};
            bit_cnt  <= next_cnt;
        end
    end

    // Status output: loaded at select fall, shifted out on rising edges.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift <= '0;
        end else if (cs_fall) begin
            tx_shift <= status_word;
        end else if (sclk_rise) begin
            tx_shift <= {tx_shift[`SWM_FRAME_BITS-2:0], 1'b0};
        end
    end

    // SO driver: enabled through the frame, the top status bit shows from the
    // select fall and each rise after the first presents the next one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            so_out <= 1'b0;
            so_oe  <= 1'b0;
        end else if (cs_fall) begin
            so_oe  <= 1'b1;
            so_out <= status_word[`SWM_FRAME_BITS-1];
        end else if (cs_rise || !vdd_q) begin
            so_oe  <= 1'b0;
        end else if (sclk_rise) begin
            so_out <= tx_shift[`SWM_FRAME_BITS-1];
        end
    end

    // ------------------------------------------------------------------------
    // Command commit
    // ------------------------------------------------------------------------

    // A short or overlong frame is dropped rather than acted upon half-formed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_word  <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= commit;
            if (commit) begin
                cmd_word <= rx_shift;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------------

    wire sw_event = sw_bus.changed & (mode == SWM_NORMAL);

    // A change during the frame keeps the line low past the select rise, so
    // the master never misses a switch; on the pending flag a set always beats a clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_pending  <= 1'b0;
            chg_in_frame <= 1'b0;
        end else begin
            if (sw_event) begin
                int_pending <= 1'b1;
            end else if (cs_rise && !chg_in_frame) begin
                int_pending <= 1'b0;
            end
            if (sw_event && sel && !cs_rise) begin
                chg_in_frame <= 1'b1;
            end else if (cs_rise || cs_fall) begin
                chg_in_frame <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode control
    // ------------------------------------------------------------------------

    // Wake sources; select and interrupt line need the logic supply, the
    // wake pin only needs the interrupt line high while that supply is up.
    wire wake_by_cs   = cs_fall & vdd_q;
    wire wake_by_int  = int_fall & wake_q & vdd_q;
    wire wake_by_pin  = wake_fall & (~vdd_q | int_q);
    wire wake_any     = wake_by_cs | wake_by_int | wake_by_pin | sw_bus.changed;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            SWM_NORMAL: begin
                if (sleep_req) begin
                    next_mode = SWM_SLEEP;
                end
            end
            SWM_SLEEP: begin
                if (wake_any) begin
                    next_mode = SWM_NORMAL;
                end
            end
        endcase
    end

    // Power-on lands in normal mode, as the battery supply does.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= SWM_NORMAL;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Open-drain pins and mode output
    // ------------------------------------------------------------------------

    // Open-drain pins only ever pull low; the enable carries the state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_n_out   <= 1'b0;
            wake_n_out  <= 1'b0;
            int_n_oe    <= 1'b0;
            wake_n_oe   <= 1'b1;
            mode_normal <= 1'b1;
        end else begin
            int_n_out   <= 1'b0;
            wake_n_out  <= 1'b0;
            int_n_oe    <= int_pending;
            wake_n_oe   <= (next_mode == SWM_NORMAL);
            mode_normal <= (next_mode == SWM_NORMAL);
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_frame_end;
        cs_rise && sel && frame_ok && word_complete;
    endsequence

    sequence s_commit_seen;
        ##1 (cmd_valid && cmd_word == $past(rx_shift));
    endsequence

    chk_so_enable_fall:  assert property (cs_fall |=> so_oe)
        else $error("SO not enabled after select fall");
    chk_so_release_rise: assert property (cs_rise |=> !so_oe)
        else $error("SO still driven after select rise");
    chk_so_idle_off:     assert property (so_oe |-> $past(!cs_q) || $past(cs_fall, 1))
        else $error("SO driven while deselected");
    chk_int_release:     assert property (cs_rise && !chg_in_frame && !sw_event |=> ##1 !int_n_oe)
        else $error("Interrupt not released at select rise");
    chk_int_hold_chg:    assert property (cs_rise && chg_in_frame |=> ##1 int_n_oe)
        else $error("Interrupt released despite change in frame");
    chk_int_on_change:   assert property (sw_event |=> ##1 int_n_oe)
        else $error("Enabled change did not assert interrupt");
    chk_cmd_commit:      assert property (s_frame_end |-> s_commit_seen)
        else $error("Command word not committed at select rise");
    chk_cmd_only_rise:   assert property (cmd_valid |-> $past(cs_rise))
        else $error("Command committed outside select rise");
    chk_si_sample:       assert property (sclk_fall |=> rx_shift[0] == $past(si_q))
        else $error("SI not sampled on clock fall");
    chk_so_msb_next:     assert property (sclk_rise && !cs_fall && !cs_rise |=> so_out == $past(tx_shift[23]))
        else $error("SO did not present next status bit");
    chk_int_flag_cap:    assert property (cs_fall |=> tx_shift[23] == $past(int_pending))
        else $error("Interrupt flag not captured at select fall");
    chk_wake_cs:         assert property (mode == SWM_SLEEP && wake_by_cs |=> mode == SWM_NORMAL ##1 wake_n_oe)
        else $error("Select fall did not wake the device");
    chk_wake_int:        assert property (mode == SWM_SLEEP && wake_by_int |=> mode == SWM_NORMAL)
        else $error("Interrupt line fall did not wake the device");
    chk_sleep_release:   assert property (mode == SWM_SLEEP && !wake_any |=> !wake_n_oe)
        else $error("Wake pin driven during sleep");

endmodule : swm_top

`default_nettype wire

// ---- dv/swm_master.sv ----
`timescale 1ns/1ns
`default_nettype none

// --------------------------------------
// Serial master model
// --------------------------------------
module swm_master (
    input  wire logic clk,
    input  wire logic so_line,
    output logic      cs_n,
    output logic      sclk,
    output logic      si
);
    // The clock stands low between frames.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // Sends nbits MSB first, gathers status.
    task automatic xfer(input logic [23:0] cmd, input int nbits, output logic [23:0] stat);
        stat = 24'h000000;
        @(posedge clk) cs_n <= 1'b0; // Falls while sclk is low.
        repeat (13) @(posedge clk);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            si   <= cmd[i];
            repeat (10) @(posedge clk);
            stat = {stat[22:0], so_line}; // Read at the falling edge.
            sclk <= 1'b0;
            repeat (10) @(posedge clk);
        end
        cs_n <= 1'b1; // Rises while sclk is low.
        repeat (12) @(posedge clk);
    endtask : xfer
endmodule : swm_master

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb;
    // --------------------------------------
    // Stimulus and wires
    // --------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0, vdd = 1'b1, therm = 1'b1, sleep_req = 1'b0;
    logic        int_pull = 1'b0, wake_pull = 1'b0;
    logic [21:0] ien = 22'h3fffff;
    wire  logic  int_drv, wake_drv;
    logic [7:0]  sp = 8'h3c, sel = 8'h0f;
    logic [13:0] sg = 14'h1234;
    logic [23:0] st;
    wire  logic  cs_n, sclk, si, so_out, so_oe, int_n_oe, wake_n_oe, mode_normal, cmd_valid;
    wire  logic [23:0] cmd_word;
    int          num_errors = 0, n_compared = 0, n_valid = 0;

    // Open-drain lines resolve against pull-ups; a released SO floats.
    wire logic int_line  = (int_n_oe ? int_drv : 1'b1) & ~int_pull;
    wire logic wake_line = (wake_n_oe ? wake_drv : 1'b1) & ~wake_pull;
    wire logic so_line   = so_oe ? so_out : 1'bz;

    // Clock, and a count of command strobes.
    always #4 clk = ~clk;
    always @(posedge clk) if (cmd_valid === 1'b1) n_valid <= n_valid + 1;

    swm_top u_swm_top (.clk(clk), .rst_n(rst_n), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
        .so_out(so_out), .so_oe(so_oe), .int_n_in(int_line), .int_n_out(int_drv), .int_n_oe(int_n_oe),
        .wake_n_in(wake_line), .wake_n_out(wake_drv), .wake_n_oe(wake_n_oe), .vdd_present(vdd),
        .prog_polarity_inputs(sp), .ground_only_inputs(sg), .sp_battery_sel(sel),
        .int_enable(ien), .thermal_flag(therm), .sleep_req(sleep_req),
        .cmd_word(cmd_word), .cmd_valid(cmd_valid), .mode_normal(mode_normal));
    swm_master u_swm_master (.clk(clk), .so_line(so_line), .cs_n(cs_n), .sclk(sclk), .si(si));

    // --------------------------------------
    // Checking helpers
    // --------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Closed reads one; battery inputs close above, ground inputs below.
    function automatic logic [23:0] exp_stat(input logic irq);
        return {irq, therm, ~sg, sp ~^ sel};
    endfunction : exp_stat

    task automatic report_and_stop;
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic go_sleep;
        @(posedge clk) sleep_req <= 1'b1;
        @(posedge clk) sleep_req <= 1'b0;
        repeat (4) @(posedge clk);
        check("sleep mode", mode_normal, 0);
        check("wake released", wake_n_oe, 0);
    endtask : go_sleep

    // --------------------------------------
    // Scenarios
    // --------------------------------------
    task automatic t_frame;
        int nv;
        nv = n_valid;
        check("idle so_oe", so_oe, 0);
        check("normal wake", wake_n_oe, 1);
        check("wake line", wake_line, 0);
        u_swm_master.xfer(24'ha5c3f0, 24, st);
        check("status", st, exp_stat(1'b0));
        check("cmd", cmd_word, 24'ha5c3f0);
        check("strobes", n_valid - nv, 1);
        check("so released", so_oe, 0);
        u_swm_master.xfer(24'h123456, 23, st);
        check("short cmd", cmd_word, 24'ha5c3f0);
        check("short strobes", n_valid - nv, 1);
    endtask : t_frame

    task automatic t_irq;
        @(posedge clk) sg[0] <= ~sg[0];
        ien <= 22'h3ffeff;
        repeat (20) @(posedge clk);
        check("masked irq", int_n_oe, 0);
        sg[0] <= ~sg[0];
        ien   <= 22'h3fffff;
        therm <= 1'b0;
        repeat (20) @(posedge clk);
        check("irq set", int_n_oe, 1);
        check("irq line", int_line, 0);
        u_swm_master.xfer(24'h000000, 24, st);
        check("irq status", st, exp_stat(1'b1));
        check("irq clear", int_n_oe, 0);
    endtask : t_irq

    task automatic t_wake;
        int nv;
        go_sleep();
        nv = n_valid;
        u_swm_master.xfer(24'hffffff, 24, st);
        check("cs wake", mode_normal, 1);
        check("wake frame dropped", n_valid - nv, 0);
        go_sleep();
        vdd <= 1'b0;
        u_swm_master.xfer(24'h000000, 24, st);
        check("no supply no wake", mode_normal, 0);
        @(posedge clk) wake_pull <= 1'b1;
        repeat (10) @(posedge clk);
        wake_pull <= 1'b0;
        check("wake pin wake", mode_normal, 1);
        vdd <= 1'b1;
        go_sleep();
        @(posedge clk) int_pull <= 1'b1;
        repeat (10) @(posedge clk);
        int_pull <= 1'b0;
        repeat (4) @(posedge clk);
        check("int line wake", mode_normal, 1);
    endtask : t_wake

    // Main sequence after a six-cycle reset.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_frame();
        t_irq();
        t_wake();
        report_and_stop();
    end

    // Watchdog well beyond the expected span of the run.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
